/* design/agib_map.vh */
// Register map and reset values of the general-purpose I/O port block.
// Assumes a 32-bit register port with byte addresses, one word per register.
`ifndef AGIB_MAP_VH
`define AGIB_MAP_VH

// Port count and register port widths
`define AGIB_NPORT 32
`define AGIB_AW 8
`define AGIB_DW 32

// Register byte offsets
`define AGIB_OFF_DOUT 8'h00
`define AGIB_OFF_DIN 8'h04
`define AGIB_OFF_OEN 8'h08
`define AGIB_OFF_IEN 8'h0c
`define AGIB_OFF_BYP 8'h10
`define AGIB_OFF_EDGE 8'h14
`define AGIB_OFF_POL 8'h18
`define AGIB_OFF_ANY 8'h1c
`define AGIB_OFF_IRQEN 8'h20
`define AGIB_OFF_IRQMSK 8'h24
`define AGIB_OFF_ISTAT 8'h28
`define AGIB_OFF_IPEND 8'h2c

// Reset values of the writable registers
`define AGIB_RST_DOUT 32'h00000000
`define AGIB_RST_OEN 32'h00000000
`define AGIB_RST_IEN 32'hffffffff
`define AGIB_RST_BYP 32'h00000000
`define AGIB_RST_EDGE 32'h00000000
`define AGIB_RST_POL 32'hffffffff
`define AGIB_RST_ANY 32'h00000000
`define AGIB_RST_IRQEN 32'h00000000
`define AGIB_RST_IRQMSK 32'h00000000

// Depth of the pad input synchroniser, in flip-flops
`define AGIB_SYNC_STAGES 3

`endif

/* design/agib_sync_evt.v */
// Pad input synchroniser and per-port event detector.
// Assumes pad inputs are asynchronous to clk_sys; controls are clk_sys.
`timescale 1ns/10ps
`default_nettype none

module agib_sync_evt #(
   parameter NPORT = 32
) (
   input wire clk_sys,
   input wire rstn,
   input wire [NPORT-1:0] pad_in,
   input wire [NPORT-1:0] in_en,
   input wire [NPORT-1:0] sel_edge,
   input wire [NPORT-1:0] sel_pol,
   input wire [NPORT-1:0] sel_any,
   output wire [NPORT-1:0] level,
   output wire [NPORT-1:0] event_hit
);

   reg [NPORT-1:0] s1_q;
   reg [NPORT-1:0] s2_q;
   reg [NPORT-1:0] s3_q;
   reg [NPORT-1:0] stable_q;
   reg [NPORT-1:0] prev_q;

   // Three-stage chain; only s2 reads s1
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s1_q <= {NPORT{1'b0}};
         s2_q <= {NPORT{1'b0}};
         s3_q <= {NPORT{1'b0}};
      end else begin
         s1_q <= pad_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Accept a new level once the second and third stage agree
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         stable_q <= {NPORT{1'b0}};
         prev_q <= {NPORT{1'b0}};
      end else begin
         stable_q <= (s2_q ~^ s3_q) & s2_q | ~(s2_q ~^ s3_q) & stable_q;
         prev_q <= stable_q;
      end
   end

   assign level = stable_q & in_en;

   // Per-port event decode
   genvar i;
   generate
      for (i = 0; i < NPORT; i = i + 1) begin : g_port
         wire rise;
         wire fall;
         wire edge_hit;
         wire lvl_hit;
         assign rise = stable_q[i] & ~prev_q[i]; // see R11
         assign fall = ~stable_q[i] & prev_q[i]; // see R11
         assign edge_hit = sel_any[i] ? (rise | fall) :
                           (sel_pol[i] ? rise : fall); // see R03
         assign lvl_hit = ~(stable_q[i] ^ sel_pol[i]); // see R11
         assign event_hit[i] = in_en[i] &
            ((sel_edge[i] | sel_any[i]) ? edge_hit : lvl_hit); // see R03
      end
   endgenerate

endmodule // agib_sync_evt

`default_nettype wire

/* design/agib_gpio.v */
// General-purpose I/O port block with event interrupt and bypass path.
// Assumes a single clock clk_sys, an async active-low reset and a simple
// register master that issues one-cycle read and write strobes.
//
// How it works
// R01: Up to 32 ports, each set as input, output or both by software.
// R02: Every port has its own pad output, output enable and pad input.
// R03: Each port picks one event: high, low, rising, falling or any edge.
// R04: Per-port interrupt enable and mask registers.
// R05: All qualified port events merge into one interrupt output.
// R06: Software reads the pending source ports and clears them by writing one.
// R07: Sampled inputs and written outputs live in readable registers.
// R08: All registers are reached only through the register port.
// R09: Per-port bypass lines link pads straight to a peripheral, unregistered.
// R10: A bypass peripheral holds its levels as long as the pad must show them.
// R11: Edges compare successive synced samples; a level holds while matched.
// R12: In bypass, pad output and enable follow bypass lines combinationally.
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "agib_map.vh"

module agib_gpio #(
   parameter NPORT = `AGIB_NPORT
) (
   input wire clk_sys,
   input wire rstn,
   input wire [`AGIB_AW-1:0] reg_addr,
   input wire [`AGIB_DW-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [`AGIB_DW-1:0] reg_rdata,
   input wire [NPORT-1:0] pad_in,
   output wire [NPORT-1:0] pad_out,
   output wire [NPORT-1:0] pad_oe,
   input wire [NPORT-1:0] byp_out,
   input wire [NPORT-1:0] byp_oe,
   output wire [NPORT-1:0] byp_in,
   output reg irq
);

   // Address match, used by every write decode; the read multiplexer uses a case
   function hit;
      input [`AGIB_AW-1:0] addr;
      input [`AGIB_AW-1:0] off;
      begin
         hit = (addr == off);
      end
   endfunction

   // Reset values at full word width, cut to the port count where used
   localparam [`AGIB_DW-1:0] RST_DOUT = `AGIB_RST_DOUT;
   localparam [`AGIB_DW-1:0] RST_OEN = `AGIB_RST_OEN;
   localparam [`AGIB_DW-1:0] RST_IEN = `AGIB_RST_IEN;
   localparam [`AGIB_DW-1:0] RST_BYP = `AGIB_RST_BYP;
   localparam [`AGIB_DW-1:0] RST_EDGE = `AGIB_RST_EDGE;
   localparam [`AGIB_DW-1:0] RST_POL = `AGIB_RST_POL;
   localparam [`AGIB_DW-1:0] RST_ANY = `AGIB_RST_ANY;
   localparam [`AGIB_DW-1:0] RST_IRQEN = `AGIB_RST_IRQEN;
   localparam [`AGIB_DW-1:0] RST_IRQMSK = `AGIB_RST_IRQMSK;

   // Software registers
   reg [NPORT-1:0] dout_q;
   reg [NPORT-1:0] oen_q;
   reg [NPORT-1:0] ien_q;
   reg [NPORT-1:0] byp_q;
   reg [NPORT-1:0] edge_q;
   reg [NPORT-1:0] pol_q;
   reg [NPORT-1:0] any_q;
   reg [NPORT-1:0] irqen_q;
   reg [NPORT-1:0] irqmsk_q;
   reg [NPORT-1:0] istat_q;
   reg [NPORT-1:0] istat_d;
   reg [`AGIB_DW-1:0] rdata_d;
   reg [`AGIB_DW-1:0] rd_word;
   reg [NPORT-1:0] irqmsk_d;

   wire [NPORT-1:0] level;
   wire [NPORT-1:0] event_hit;
   wire [NPORT-1:0] ipend;
   wire [NPORT-1:0] clr_mask;

   // Write strobes per register
   wire wr_dout;
   wire wr_oen;
   wire wr_ien;
   wire wr_byp;
   wire wr_edge;
   wire wr_pol;
   wire wr_any;
   wire wr_irqen;
   wire wr_irqmsk;
   wire wr_istat;

   assign wr_dout = reg_wr & hit(reg_addr, `AGIB_OFF_DOUT); // see R08
   assign wr_oen = reg_wr & hit(reg_addr, `AGIB_OFF_OEN);
   assign wr_ien = reg_wr & hit(reg_addr, `AGIB_OFF_IEN);
   assign wr_byp = reg_wr & hit(reg_addr, `AGIB_OFF_BYP);
   assign wr_edge = reg_wr & hit(reg_addr, `AGIB_OFF_EDGE);
   assign wr_pol = reg_wr & hit(reg_addr, `AGIB_OFF_POL);
   assign wr_any = reg_wr & hit(reg_addr, `AGIB_OFF_ANY);
   assign wr_irqen = reg_wr & hit(reg_addr, `AGIB_OFF_IRQEN);
   assign wr_irqmsk = reg_wr & hit(reg_addr, `AGIB_OFF_IRQMSK);
   assign wr_istat = reg_wr & hit(reg_addr, `AGIB_OFF_ISTAT);

   // Output data register
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         dout_q <= RST_DOUT[NPORT-1:0];
      end else if (wr_dout) begin
         dout_q <= reg_wdata[NPORT-1:0]; // see R07
      end
   end

   // Direction: drive enable and input enable give in, out or both
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         oen_q <= RST_OEN[NPORT-1:0];
         ien_q <= RST_IEN[NPORT-1:0];
      end else begin
         if (wr_oen) begin
            oen_q <= reg_wdata[NPORT-1:0]; // see R01
         end
         if (wr_ien) begin
            ien_q <= reg_wdata[NPORT-1:0]; // see R01
         end
      end
   end

   // Bypass select per port
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         byp_q <= RST_BYP[NPORT-1:0];
      end else if (wr_byp) begin
         byp_q <= reg_wdata[NPORT-1:0]; // see R09
      end
   end

   // Event type selection
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         edge_q <= RST_EDGE[NPORT-1:0];
         pol_q <= RST_POL[NPORT-1:0];
         any_q <= RST_ANY[NPORT-1:0];
      end else begin
         if (wr_edge) begin
            edge_q <= reg_wdata[NPORT-1:0]; // see R03
         end
         if (wr_pol) begin
            pol_q <= reg_wdata[NPORT-1:0]; // see R03
         end
         if (wr_any) begin
            any_q <= reg_wdata[NPORT-1:0]; // see R03
         end
      end
   end

   // Interrupt enable and mask
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irqen_q <= RST_IRQEN[NPORT-1:0];
         irqmsk_q <= RST_IRQMSK[NPORT-1:0];
      end else begin
         if (wr_irqen) begin
            irqen_q <= reg_wdata[NPORT-1:0]; // see R04
         end
         if (wr_irqmsk) begin
            irqmsk_q <= reg_wdata[NPORT-1:0]; // see R04
         end
      end
   end

   // Synchroniser and event detector for all pads
   agib_sync_evt #(
      .NPORT(NPORT)
   ) u_sync_evt (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .pad_in(pad_in),
      .in_en(ien_q),
      .sel_edge(edge_q),
      .sel_pol(pol_q),
      .sel_any(any_q),
      .level(level),
      .event_hit(event_hit)
   );

   // Status: enabled events set, write-one clears, set wins
   assign clr_mask = wr_istat ? reg_wdata[NPORT-1:0] : {NPORT{1'b0}};

   always @* begin
      istat_d = (istat_q & ~clr_mask) | (event_hit & irqen_q); // see R06
   end

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         istat_q <= {NPORT{1'b0}};
      end else begin
         istat_q <= istat_d; // see R04
      end
   end

   // Pending sources are status bits that the mask lets through
   assign ipend = istat_q & irqmsk_q; // see R04

   // Mask as it stands after this edge, so irq follows a mask write at once
   always @* begin
      irqmsk_d = wr_irqmsk ? reg_wdata[NPORT-1:0] : irqmsk_q; // see R04
   end

   // Single interrupt request, registered from the next status and mask
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(istat_d & irqmsk_d); // see R05
      end
   end

   // Read multiplexer; ports above NPORT and unmapped words read zero
   always @* begin
      rd_word = {`AGIB_DW{1'b0}};
      case (reg_addr)
         `AGIB_OFF_DOUT: rd_word[NPORT-1:0] = dout_q; // see R07
         `AGIB_OFF_DIN: rd_word[NPORT-1:0] = level; // see R07
         `AGIB_OFF_OEN: rd_word[NPORT-1:0] = oen_q;
         `AGIB_OFF_IEN: rd_word[NPORT-1:0] = ien_q;
         `AGIB_OFF_BYP: rd_word[NPORT-1:0] = byp_q;
         `AGIB_OFF_EDGE: rd_word[NPORT-1:0] = edge_q;
         `AGIB_OFF_POL: rd_word[NPORT-1:0] = pol_q;
         `AGIB_OFF_ANY: rd_word[NPORT-1:0] = any_q;
         `AGIB_OFF_IRQEN: rd_word[NPORT-1:0] = irqen_q;
         `AGIB_OFF_IRQMSK: rd_word[NPORT-1:0] = irqmsk_q;
         `AGIB_OFF_ISTAT: rd_word[NPORT-1:0] = istat_q; // see R06
         `AGIB_OFF_IPEND: rd_word[NPORT-1:0] = ipend; // see R06
         default: rd_word = {`AGIB_DW{1'b0}};
      endcase
   end

   // Read data stands for the one cycle after the strobe, else zero
   always @* begin
      rdata_d = reg_rd ? rd_word : {`AGIB_DW{1'b0}};
   end

   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= {`AGIB_DW{1'b0}};
      end else begin
         reg_rdata <= rdata_d; // see R08
      end
   end

   // Pad drive per port: bypass lines pass straight through when selected
   genvar gp;
   generate
      for (gp = 0; gp < NPORT; gp = gp + 1) begin : g_pad
         // No register on this path, the peripheral must hold its levels
         assign pad_out[gp] = byp_q[gp] ? byp_out[gp] : dout_q[gp]; // see R12
         assign pad_oe[gp] = byp_q[gp] ? byp_oe[gp] : oen_q[gp]; // see R02
      end
   endgenerate

   // Bypass input follows the pad with no register
   assign byp_in = pad_in; // see R09

endmodule // agib_gpio

`default_nettype wire

/* sim/agib_gpio_monitor.sv */
// Port checker for the I/O block: register port, pads, bypass, interrupt.
// Assumes it is bound to agib_gpio and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
`include "agib_map.vh"
module agib_gpio_monitor #(parameter NPORT = 32) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [`AGIB_AW-1:0] reg_addr,
   input wire logic [`AGIB_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [`AGIB_DW-1:0] reg_rdata,
   input wire logic [NPORT-1:0] pad_in,
   input wire logic [NPORT-1:0] pad_out,
   input wire logic [NPORT-1:0] pad_oe,
   input wire logic [NPORT-1:0] byp_out,
   input wire logic [NPORT-1:0] byp_oe,
   input wire logic [NPORT-1:0] byp_in,
   input wire logic irq
);
   logic [NPORT-1:0] byp_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // Shadow of the bypass select, taken from register writes
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn)
         byp_q <= '0;
      else if (reg_wr && reg_addr == `AGIB_OFF_BYP)
         byp_q <= reg_wdata[NPORT-1:0];
   end
   // Properties on the register port, pads and interrupt
   property p_rd_idle; !reg_rd |=> reg_rdata == '0; endproperty
   property p_unmap; reg_rd && reg_addr > 8'h2c |=> reg_rdata == '0;
   endproperty
   property p_dout; reg_wr && reg_addr == 8'h00 && byp_q == '0
      |=> pad_out == $past(reg_wdata[NPORT-1:0]); endproperty
   property p_oen; reg_wr && reg_addr == 8'h08 && byp_q == '0
      |=> pad_oe == $past(reg_wdata[NPORT-1:0]); endproperty
   property p_byp; ((pad_out ^ byp_out) & byp_q) == '0
      && ((pad_oe ^ byp_oe) & byp_q) == '0; endproperty
   property p_byp_in; byp_in == pad_in; endproperty
   property p_irq; reg_rd && reg_addr == 8'h2c && !$past(reg_wr)
      |=> (reg_rdata != '0) == $past(irq); endproperty
   property p_rst; $rose(rstn) |-> !irq && reg_rdata == '0
      && pad_oe == '0; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("rdata not idle");
   a_unmap: assert property (p_unmap)
      else $error("unmapped read");
   a_dout: assert property (p_dout)
      else $error("pad out mismatch");
   a_oen: assert property (p_oen)
      else $error("pad enable mismatch");
   a_byp: assert property (p_byp)
      else $error("bypass drive wrong");
   a_byp_in: assert property (p_byp_in)
      else $error("bypass input wrong");
   a_irq: assert property (p_irq)
      else $error("irq and pending differ");
   a_rst: assert property (p_rst)
      else $error("reset outputs wrong");
   // Main scenarios reached
   c_pend: cover property (reg_rd && reg_addr == 8'h2c ##1 reg_rdata != '0);
   c_irq: cover property ($rose(irq));
   c_byp: cover property (byp_q != '0 && byp_oe != '0);
endmodule // agib_gpio_monitor
bind agib_gpio agib_gpio_monitor #(.NPORT(NPORT)) u_mon (
   .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out),
   .pad_oe(pad_oe), .byp_out(byp_out), .byp_oe(byp_oe),
   .byp_in(byp_in), .irq(irq));
`default_nettype wire

/* sim/agib_pad_model.sv */
// Far side: outside pad drivers with pull-ups and a bypass peripheral.
// Assumes the bench sets the wanted levels in the clk_sys domain.
`timescale 1ns/10ps
`default_nettype none
module agib_pad_model #(parameter NPORT = 32) (
   input wire logic clk_sys,
   input wire logic [NPORT-1:0] ext_lvl,
   input wire logic [NPORT-1:0] ext_oe,
   input wire logic [NPORT-1:0] pad_out,
   input wire logic [NPORT-1:0] pad_oe,
   input wire logic [NPORT-1:0] byp_set,
   input wire logic [NPORT-1:0] byp_en_set,
   output wire logic [NPORT-1:0] pad_in,
   output logic [NPORT-1:0] byp_out,
   output logic [NPORT-1:0] byp_oe
);
   // Wire level: block drive wins, then outside drive, else pull-up
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_lvl)
      | (~pad_oe & ~ext_oe);
   initial begin
      byp_out = '0;
      byp_oe = '0;
   end
   // Peripheral holds its bypass levels until told otherwise
   always @(posedge clk_sys) begin
      byp_out <= byp_set;
      byp_oe <= byp_en_set;
   end
endmodule // agib_pad_model
`default_nettype wire

/* sim/apb_gpio_with_interrupt_and_bypass_tb.sv */
// Self-checking bench: register model, event modes, direction, bypass.
// Assumes the pad model stands on the far side of the pads.
`timescale 1ns/10ps
`default_nettype none
`include "agib_map.vh"
module apb_gpio_with_interrupt_and_bypass_tb;
   logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = '0, ext_lvl = '0, ext_oe = '1, r, m [12];
   logic [31:0] byp_set = '0, byp_en_set = '0, byp_out, byp_oe;
   logic [31:0] e_oe, e_out;
   wire [31:0] reg_rdata, pad_in, pad_out, pad_oe, byp_in;
   wire irq;
   logic [3:0] md [5] = '{4'b0100, 4'b0001, 4'b1100, 4'b1001, 4'b1010};
   int failures = 0, n_compared = 0, p, k;
   agib_gpio #(.NPORT(32)) DUT (.clk_sys(clk_sys), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .byp_out(byp_out),
      .byp_oe(byp_oe), .byp_in(byp_in), .irq(irq));
   agib_pad_model #(.NPORT(32)) u_pad (.clk_sys(clk_sys),
      .ext_lvl(ext_lvl), .ext_oe(ext_oe), .pad_out(pad_out),
      .pad_oe(pad_oe), .byp_set(byp_set), .byp_en_set(byp_en_set),
      .pad_in(pad_in), .byp_out(byp_out), .byp_oe(byp_oe));
   always #12.5 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One-cycle write; the model keeps what a writable register holds
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      if (a <= 8'h24 && a != 8'h04) m[a[5:2]] = d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // One-cycle read, data taken in the following cycle
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog: the tests need well under 2000 cycles
   initial begin
      #(25 * 4000);
      failures++;
      summarize;
   end
   initial begin
      r = $urandom(32'hcb0939ef);
      m = '{`AGIB_RST_DOUT, 32'h0, `AGIB_RST_OEN, `AGIB_RST_IEN,
         `AGIB_RST_BYP, `AGIB_RST_EDGE, `AGIB_RST_POL, `AGIB_RST_ANY,
         `AGIB_RST_IRQEN, `AGIB_RST_IRQMSK, 32'h0, 32'h0};
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      for (k = 0; k < 12; k++) rc(8'(k * 4), m[k]);
      for (k = 0; k < 10; k++) if (k != 1) wr(8'(k * 4), $urandom);
      for (k = 0; k < 10; k++) if (k != 1) rc(8'(k * 4), m[k]);
      wr(8'h30, $urandom);
      rc(8'h30, 32'h0);
      $display("test regs done");
      wr(`AGIB_OFF_OEN, 32'h0);
      wr(`AGIB_OFF_BYP, 32'h0);
      wr(`AGIB_OFF_IEN, 32'hffffffff);
      // Each event mode: idle gives nothing, the change sets the port
      foreach (md[i]) begin
         p = $urandom % 32;
         ext_lvl <= {32{md[i][0]}};
         wr(`AGIB_OFF_EDGE, {32{md[i][3]}});
         wr(`AGIB_OFF_POL, {32{md[i][2]}});
         wr(`AGIB_OFF_ANY, {32{md[i][1]}});
         wr(`AGIB_OFF_IRQMSK, 32'h1 << p);
         wr(`AGIB_OFF_IRQEN, 32'h1 << p);
         repeat (6) @(posedge clk_sys);
         wr(`AGIB_OFF_ISTAT, 32'hffffffff);
         rc(`AGIB_OFF_ISTAT, 32'h0);
         ext_lvl[p] <= ~md[i][0];
         repeat (8) @(posedge clk_sys);
         rc(`AGIB_OFF_ISTAT, 32'h1 << p);
         chk({31'h0, irq}, 32'h1);
         wr(`AGIB_OFF_IRQMSK, 32'h0);
         rc(`AGIB_OFF_IPEND, 32'h0);
         chk({31'h0, irq}, 32'h0);
         wr(`AGIB_OFF_IRQMSK, 32'h1 << p);
         wr(`AGIB_OFF_ISTAT, 32'hffffffff);
         rc(`AGIB_OFF_ISTAT, md[i][3] ? 32'h0 : 32'h1 << p);
         chk({31'h0, irq}, {31'h0, ~md[i][3]});
      end
      $display("test events done");
      // Two-way, output-only, input-only and disabled port groups
      r = $urandom;
      ext_lvl <= r;
      wr(`AGIB_OFF_DOUT, ~r);
      wr(`AGIB_OFF_OEN, 32'h0000ffff);
      wr(`AGIB_OFF_IEN, 32'h00ff00ff);
      repeat (6) @(posedge clk_sys);
      rc(`AGIB_OFF_DIN, {r[31:16], ~r[15:0]} & 32'h00ff00ff);
      chk(pad_oe, 32'h0000ffff);
      chk(pad_out, ~r);
      $display("test direction done");
      // Bypass lines must reach the pads in the cycle they change
      for (k = 0; k < 4; k++) begin
         r = $urandom;
         wr(`AGIB_OFF_BYP, r);
         byp_set <= $urandom;
         byp_en_set <= $urandom;
         @(posedge clk_sys);
         #1 e_out = (byp_out & r) | (m[0] & ~r);
         e_oe = (byp_oe & r) | (m[2] & ~r);
         chk(pad_out, e_out);
         chk(pad_oe, e_oe);
         // Pad level from the model: own drive wins, else outside level
         chk(byp_in, (e_oe & e_out) | (~e_oe & ext_lvl));
      end
      $display("test bypass done");
      summarize;
   end
endmodule // apb_gpio_with_interrupt_and_bypass_tb
`default_nettype wire
